/* File: acd_map.svh */
// Bit positions, reset values and timing figures of the command byte decoder
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH

// ----------------------------------------------------------------
// Register select prefix bits
// ----------------------------------------------------------------
`define ACD_CONV_SEL_BIT   7
`define ACD_SETUP_SEL_BIT  6
`define ACD_AVG_SEL_BIT    5
`define ACD_RST_SEL_BIT    4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACD_CHAN_HI        6
`define ACD_CHAN_LO        3
`define ACD_SWEEP_HI       2
`define ACD_SWEEP_LO       1
`define ACD_TIMING_HI      5
`define ACD_TIMING_LO      4
`define ACD_VREF_HI        3
`define ACD_VREF_LO        2
`define ACD_AVG_EN_BIT     4
`define ACD_AVG_CNT_HI     3
`define ACD_AVG_CNT_LO     2
`define ACD_REP_CNT_HI     1
`define ACD_REP_CNT_LO     0
`define ACD_RST_FIFO_BIT   3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define ACD_TIMING_RST     2'h2
`define ACD_FIELD2_RST     2'h0
`define ACD_CHAN_RST       4'h0
`define ACD_AVG_SHIFT_MIN  3'h2
`define ACD_REP_STEP_LOG   2'h0
`define ACD_BITS_PER_BYTE  3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACD_REF_WAKE_NS    65000
`define ACD_SYS_CLK_NS     10

`endif

/* File: acd_pkg.sv */
// Types shared by the command byte decoder modules
`default_nettype none

package acd_pkg;
	typedef enum {ST_IDLE, ST_WAKE, ST_NEXT, ST_WAIT, ST_DONE} acd_state_t;
	typedef enum logic [1:0] {SWEEP_LOW_TO_N, SWEEP_N_TO_TOP, SWEEP_REPEAT, SWEEP_SINGLE} acd_sweep_t;
	typedef enum logic [1:0] {TIM_PIN_INT, TIM_PIN_EXT_ACQ, TIM_SERIAL_INT, TIM_SERIAL_EXT}
		acd_timing_t;
	typedef enum logic [1:0] {VREF_INT_AUTO, VREF_EXT, VREF_INT_ON, VREF_UNDEF} acd_vref_t;
	typedef enum logic [2:0] {CMD_NONE, CMD_CONV, CMD_SETUP, CMD_AVG, CMD_RESET} acd_cmd_t;
endpackage

`default_nettype wire

/* File: acd_byte_if.sv */
// Received command byte passed from the serial receiver to the decoder
`default_nettype none

interface acd_byte_if;
	logic       valid;
	logic [7:0] data;
	modport rx  (output valid, output data);
	modport dec (input valid, input data);
endinterface

`default_nettype wire

/* File: acd_serial_rx.sv */
// Serial command byte receiver: synchronises the pins and shifts bytes in
`include "acd_map.svh"
`default_nettype none

module acd_serial_rx
(
	input  wire logic i_sys_clk,
	input  wire logic i_rst_sync_b,
	input  wire logic i_sclk,
	input  wire logic i_cs_b,
	input  wire logic i_din,
	acd_byte_if.rx    byte_out
);
	import acd_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic       sclk_old_reg;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic       valid_reg;
	logic       valid_next;
	logic       sclk_rise;

	always_ff @(posedge i_sys_clk or negedge i_rst_sync_b)
	begin
		if (!i_rst_sync_b)
		begin
			meta_reg     <= 3'h7;
			sync_reg     <= 3'h7;
			// Matches the synchroniser's reset level so no false edge follows reset
			sclk_old_reg <= 1'b1;
		end
		else
		begin
			meta_reg     <= {i_sclk, i_cs_b, i_din};
			sync_reg     <= meta_reg;
			sclk_old_reg <= sync_reg[2];
		end
	end

	// ----------------------------------------------------------------
	// Shift register, MSB first, decoded only after eight bits
	// ----------------------------------------------------------------
	assign sclk_rise = sync_reg[2] && !sclk_old_reg;

	always_comb
	begin
		shift_next   = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		valid_next   = 1'b0;
		if (sync_reg[1])
			bit_cnt_next = 3'h0;
		else if (sclk_rise)
		begin
			shift_next   = {shift_reg[6:0], sync_reg[0]}; // R28
			bit_cnt_next = bit_cnt_reg + 3'h1;
			valid_next   = (bit_cnt_reg == `ACD_BITS_PER_BYTE); // R28
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_sync_b)
	begin
		if (!i_rst_sync_b)
		begin
			shift_reg   <= 8'h00;
			bit_cnt_reg <= 3'h0;
			valid_reg   <= 1'b0;
		end
		else
		begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			valid_reg   <= valid_next;
		end
	end

	assign byte_out.valid = valid_reg;
	assign byte_out.data  = shift_reg;

	byte_cs_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_sync_b)
		valid_reg |-> $past(!sync_reg[1])) else $error("byte completed with select high"); // R28
endmodule // acd_serial_rx

`default_nettype wire

/* File: acd_decoder.sv */
// Command byte decoder and scan sequencer of the serial converter
//
// Notes on behaviour
// [R1] Bit7 set: channel and sweep mode write
// [R2] Prefix 01: timing and reference mode write
// [R3] Averaging up to 32, separate repeat count
// [R4] Channel field is plain binary input number
// [R5] Sweep 00: channels zero up to N
// [R6] Sweep 01: channel N up to top
// [R7] Sweep 10: channel N, repeat-count results
// [R8] Sweep 11: channel N, one result
// [R9] Skip channel used as conversion start pin
// [R10] Host avoids channels 8-15 on small parts
// [R11] Serial write or start pin requests scan
// [R12] Timing 00/01: internal clock, pin starts
// [R13] Timing 10 internal; 11 serial clock
// [R14] Upper timing bit resets to one
// [R15] Reference 00: auto off, wake-up delay; code skips the delay in timing 01
// [R16] Reference 01: external, no wake-up delay
// [R17] Reference 10: internal, always powered
// [R18] Averaging applies when enable bit set, except in timing 11
// [R19] Timing 11 ignores averaging settings
// [R20] Reset bit1 clears FIFO, bit0 everything
// [R21] Scan time: samples times results plus wake
// [R22] Host times timing mode 01 conversions
// [R23] Prefix 001 averaging, 0001 reset write
// [R24] Averaging count selects 4/8/16/32 samples
// [R25] Repeat count selects 4/8/12/16 results
// [R26] Power-up: all zero, timing mode 10
// [R27] Undefined reference code keeps reference off
// [R28] Byte shifted MSB first, eight bits
`include "acd_map.svh"
`default_nettype none

module acd_decoder #(
	parameter int CHANNELS     = 16,
	parameter int REF_WAKE_CYC = `ACD_REF_WAKE_NS / `ACD_SYS_CLK_NS
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_sclk,
	input  wire logic       i_cs_b,
	input  wire logic       i_din,
	input  wire logic       i_conversion_start_pin_b,
	input  wire logic       i_sample_done,
	output logic            o_sample_req,
	output logic [3:0]      o_sample_chan,
	output logic            o_result_store,
	output logic            o_scan_done,
	output logic            o_busy,
	output logic            o_ref_on,
	output logic            o_ext_ref,
	output logic            o_ext_conv_clk,
	output logic            o_start_pin_en,
	output logic            o_fifo_clear
);
	import acd_pkg::*;

	localparam int         WW       = $clog2(REF_WAKE_CYC + 1);
	localparam logic [3:0] TOP_CHAN = 4'(CHANNELS - 1);

	function automatic acd_cmd_t cmd_kind(input logic [7:0] b);
		if (b[`ACD_CONV_SEL_BIT])
			return CMD_CONV;
		else if (b[`ACD_SETUP_SEL_BIT])
			return CMD_SETUP;
		else if (b[`ACD_AVG_SEL_BIT])
			return CMD_AVG;
		else if (b[`ACD_RST_SEL_BIT])
			return CMD_RESET;
		return CMD_NONE;
	endfunction

	// ----------------------------------------------------------------
	// Reset release and start pin synchroniser
	// ----------------------------------------------------------------
	logic [1:0] rst_pipe_reg;
	logic       rst_sync_b;
	logic [2:0] conversion_start_pin_pipe_reg;
	logic       conversion_start_pin_fall;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_sync_b = rst_pipe_reg[1];

	always_ff @(posedge i_sys_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			conversion_start_pin_pipe_reg <= 3'h7;
		else
			conversion_start_pin_pipe_reg <= {conversion_start_pin_pipe_reg[1:0], i_conversion_start_pin_b};
	end
	assign conversion_start_pin_fall = conversion_start_pin_pipe_reg[2] && !conversion_start_pin_pipe_reg[1];

	acd_byte_if rx_if ();

	acd_serial_rx u_rx (
		.i_sys_clk    (i_sys_clk),
		.i_rst_sync_b (rst_sync_b),
		.i_sclk       (i_sclk),
		.i_cs_b       (i_cs_b),
		.i_din        (i_din),
		.byte_out     (rx_if.rx)
	);

	// ----------------------------------------------------------------
	// Write-only registers
	// ----------------------------------------------------------------
	acd_cmd_t    cmd;
	logic        soft_rst;
	logic        fifo_clr;
	logic [3:0]  chan_reg,  chan_next;
	acd_sweep_t  sweep_reg, sweep_next;
	acd_timing_t tim_reg,   tim_next;
	acd_vref_t   vref_reg,  vref_next;
	logic        avg_en_reg, avg_en_next;
	logic [1:0]  avg_cnt_reg, avg_cnt_next;
	logic [1:0]  rep_cnt_reg, rep_cnt_next;
	logic        ext_ref_reg, ext_ref_next;
	logic        eclk_reg,    eclk_next;
	logic        pin_en_reg,  pin_en_next;

	assign cmd      = rx_if.valid ? cmd_kind(rx_if.data) : CMD_NONE; // R23
	assign soft_rst = (cmd == CMD_RESET) && !rx_if.data[`ACD_RST_FIFO_BIT]; // R20
	assign fifo_clr = (cmd == CMD_RESET) && rx_if.data[`ACD_RST_FIFO_BIT]; // R20

	always_comb
	begin
		chan_next    = chan_reg;
		sweep_next   = sweep_reg;
		tim_next     = tim_reg;
		vref_next    = vref_reg;
		avg_en_next  = avg_en_reg;
		avg_cnt_next = avg_cnt_reg;
		rep_cnt_next = rep_cnt_reg;
		if (soft_rst)
		begin
			chan_next    = `ACD_CHAN_RST; // R26
			sweep_next   = acd_sweep_t'(`ACD_FIELD2_RST);
			tim_next     = acd_timing_t'(`ACD_TIMING_RST); // R14
			vref_next    = acd_vref_t'(`ACD_FIELD2_RST);
			avg_en_next  = 1'b0;
			avg_cnt_next = `ACD_FIELD2_RST;
			rep_cnt_next = `ACD_FIELD2_RST;
		end
		else if (cmd == CMD_CONV)
		begin
			chan_next  = rx_if.data[`ACD_CHAN_HI:`ACD_CHAN_LO]; // R1 R4
			sweep_next = acd_sweep_t'(rx_if.data[`ACD_SWEEP_HI:`ACD_SWEEP_LO]); // R1
		end
		else if (cmd == CMD_SETUP)
		begin
			tim_next  = acd_timing_t'(rx_if.data[`ACD_TIMING_HI:`ACD_TIMING_LO]); // R2
			vref_next = acd_vref_t'(rx_if.data[`ACD_VREF_HI:`ACD_VREF_LO]); // R2
		end
		else if (cmd == CMD_AVG)
		begin
			avg_en_next  = rx_if.data[`ACD_AVG_EN_BIT]; // R18
			avg_cnt_next = rx_if.data[`ACD_AVG_CNT_HI:`ACD_AVG_CNT_LO]; // R3
			rep_cnt_next = rx_if.data[`ACD_REP_CNT_HI:`ACD_REP_CNT_LO]; // R3
		end
		ext_ref_next = vref_next == VREF_EXT; // R16
		eclk_next    = tim_next == TIM_SERIAL_EXT; // R13
		pin_en_next  = (tim_next == TIM_PIN_INT) || (tim_next == TIM_PIN_EXT_ACQ); // R12
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			chan_reg    <= `ACD_CHAN_RST;
			sweep_reg   <= acd_sweep_t'(`ACD_FIELD2_RST);
			tim_reg     <= acd_timing_t'(`ACD_TIMING_RST); // R14 R26
			vref_reg    <= acd_vref_t'(`ACD_FIELD2_RST);
			avg_en_reg  <= 1'b0;
			avg_cnt_reg <= `ACD_FIELD2_RST;
			rep_cnt_reg <= `ACD_FIELD2_RST;
			ext_ref_reg <= 1'b0;
			eclk_reg    <= 1'b0;
			pin_en_reg  <= 1'b0;
		end
		else
		begin
			chan_reg    <= chan_next;
			sweep_reg   <= sweep_next;
			tim_reg     <= tim_next;
			vref_reg    <= vref_next;
			avg_en_reg  <= avg_en_next;
			avg_cnt_reg <= avg_cnt_next;
			rep_cnt_reg <= rep_cnt_next;
			ext_ref_reg <= ext_ref_next;
			eclk_reg    <= eclk_next;
			pin_en_reg  <= pin_en_next;
		end
	end

	// ----------------------------------------------------------------
	// Scan sequencer
	// ----------------------------------------------------------------
	acd_state_t state_reg, state_next;
	logic [3:0] cur_reg, cur_next;
	logic [3:0] last_reg, last_next;
	logic       rep_reg, rep_next;
	logic [5:0] samp_reg, samp_next;
	logic [4:0] res_reg, res_next;
	logic [WW-1:0] wake_reg, wake_next;
	logic       armed_reg, armed_next;
	logic       req_reg, req_next;
	logic       store_reg, store_next;
	logic       done_reg, done_next;
	logic       clr_reg, clr_next;
	logic       busy_reg, busy_next;
	logic       refon_reg, refon_next;
	logic       pin_start;
	logic       single;
	logic       start;
	logic       skip;
	logic       advance;
	logic [5:0] spr;
	logic [4:0] nres;

	assign pin_start = (tim_reg == TIM_PIN_INT) || (tim_reg == TIM_PIN_EXT_ACQ); // R12
	// Serial-clocked timing disables both sweeping and averaging
	assign single = (tim_next == TIM_SERIAL_EXT) || (sweep_next == SWEEP_SINGLE); // R8 R13
	assign start  = (state_reg == ST_IDLE) && !soft_rst &&
		(pin_start ? conversion_start_pin_fall : (cmd == CMD_CONV)); // R11
	assign skip   = pin_start && (cur_reg == TOP_CHAN); // R9
	assign spr    = (avg_en_reg && tim_reg != TIM_SERIAL_EXT) ?
		6'(6'h01 << (3'(avg_cnt_reg) + `ACD_AVG_SHIFT_MIN)) : 6'h01; // R18 R19 R24
	assign nres   = {3'(rep_cnt_reg) + 3'h1, `ACD_REP_STEP_LOG}; // R25

	always_comb
	begin
		state_next = state_reg;
		cur_next   = cur_reg;
		last_next  = last_reg;
		rep_next   = rep_reg;
		samp_next  = samp_reg;
		res_next   = res_reg;
		wake_next  = wake_reg;
		armed_next = armed_reg || conversion_start_pin_fall;
		req_next   = 1'b0;
		store_next = 1'b0;
		done_next  = 1'b0;
		clr_next   = fifo_clr; // R20
		advance    = 1'b0;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (start)
				begin
					cur_next   = (!single && sweep_next == SWEEP_LOW_TO_N) ? 4'h0 : chan_next; // R5
					last_next  = (!single && sweep_next == SWEEP_N_TO_TOP) ? TOP_CHAN : chan_next; // R6
					rep_next   = !single && sweep_next == SWEEP_REPEAT; // R7
					samp_next  = 6'h00;
					res_next   = 5'h00;
					armed_next = 1'b1;
					wake_next  = WW'(REF_WAKE_CYC);
					// Host owns reference settling in timing mode 01
					state_next = (vref_reg == VREF_INT_AUTO && tim_reg != TIM_PIN_EXT_ACQ) ?
						ST_WAKE : ST_NEXT; // R15 R16 R17 R21 R22
				end
			end
			ST_WAKE:
			begin
				wake_next = wake_reg - WW'(1);
				if (wake_reg == WW'(1))
					state_next = ST_NEXT; // R21
			end
			ST_NEXT:
			begin
				if (skip)
					advance = 1'b1; // R9
				else if (tim_reg != TIM_PIN_EXT_ACQ || armed_reg)
				begin
					req_next   = 1'b1;
					armed_next = 1'b0; // R12
					state_next = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (i_sample_done)
				begin
					if (samp_reg + 6'h01 == spr)
					begin
						samp_next  = 6'h00;
						store_next = 1'b1; // R24
						advance    = 1'b1;
					end
					else
					begin
						samp_next  = samp_reg + 6'h01;
						state_next = ST_NEXT;
					end
				end
			end
			ST_DONE:
			begin
				done_next  = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
		if (advance)
		begin
			if (rep_reg && (res_reg + 5'h01 != nres))
			begin
				res_next   = res_reg + 5'h01; // R7 R25
				state_next = ST_NEXT;
			end
			else if (cur_reg == last_reg)
				state_next = ST_DONE;
			else
			begin
				cur_next   = cur_reg + 4'h1;
				state_next = ST_NEXT;
			end
		end
		if (soft_rst)
			state_next = ST_IDLE; // R20
		busy_next  = state_next != ST_IDLE;
		refon_next = (vref_next == VREF_INT_ON) ||
			(vref_next == VREF_INT_AUTO && busy_next); // R15 R17 R27
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			state_reg <= ST_IDLE;
			cur_reg   <= 4'h0;
			last_reg  <= 4'h0;
			rep_reg   <= 1'b0;
			samp_reg  <= 6'h00;
			res_reg   <= 5'h00;
			wake_reg  <= '0;
			armed_reg <= 1'b0;
			req_reg   <= 1'b0;
			store_reg <= 1'b0;
			done_reg  <= 1'b0;
			clr_reg   <= 1'b0;
			busy_reg  <= 1'b0;
			refon_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cur_reg   <= cur_next;
			last_reg  <= last_next;
			rep_reg   <= rep_next;
			samp_reg  <= samp_next;
			res_reg   <= res_next;
			wake_reg  <= wake_next;
			armed_reg <= armed_next;
			req_reg   <= req_next;
			store_reg <= store_next;
			done_reg  <= done_next;
			clr_reg   <= clr_next;
			busy_reg  <= busy_next;
			refon_reg <= refon_next;
		end
	end

	assign o_sample_req   = req_reg;
	assign o_sample_chan  = cur_reg;
	assign o_result_store = store_reg;
	assign o_scan_done    = done_reg;
	assign o_busy         = busy_reg;
	assign o_ref_on       = refon_reg;
	assign o_ext_ref      = ext_ref_reg; // R16
	assign o_ext_conv_clk = eclk_reg; // R13
	assign o_start_pin_en = pin_en_reg; // R12
	assign o_fifo_clear   = clr_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking dc @(posedge i_sys_clk); endclocking
	default disable iff (!rst_sync_b);

	sequence conv_write_s;
		rx_if.valid && rx_if.data[`ACD_CONV_SEL_BIT];
	endsequence

	conv_decode_a: assert property (conv_write_s |=> chan_reg == $past(rx_if.data[6:3])) // R1
		else $error("channel field not loaded");
	setup_decode_a: assert property (rx_if.valid && rx_if.data[7:6] == 2'h1 |=> // R2
		tim_reg == acd_timing_t'($past(rx_if.data[5:4]))) else $error("timing mode not loaded");
	avg_decode_a: assert property (rx_if.valid && rx_if.data[7:5] == 3'h1 |=> // R23
		rep_cnt_reg == $past(rx_if.data[1:0])) else $error("repeat count not loaded");
	soft_reset_a: assert property (rx_if.valid && rx_if.data[7:3] == 5'h02 |=> // R26
		tim_reg == TIM_SERIAL_INT && chan_reg == 4'h0 && !busy_reg) else $error("soft reset");
	fifo_clear_a: assert property (rx_if.valid && rx_if.data[7:3] == 5'h03 |=> // R20
		o_fifo_clear ##1 !o_fifo_clear) else $error("FIFO clear pulse wrong");
	serial_start_a: assert property ((conv_write_s and (tim_reg == TIM_SERIAL_INT && // R11
		state_reg == ST_IDLE)) |=> busy_reg) else $error("serial write did not start scan");
	pin_skip_a: assert property (o_sample_req && o_start_pin_en |-> // R9
		o_sample_chan != TOP_CHAN) else $error("start pin channel converted");
	wake_delay_a: assert property ($rose(o_busy) && vref_reg == VREF_INT_AUTO && // R15
		tim_reg == TIM_SERIAL_INT |-> (!o_sample_req && o_ref_on) [*8]) else $error("no wake-up");
	ext_no_avg_a: assert property (state_reg == ST_WAIT && i_sample_done && // R19
		tim_reg == TIM_SERIAL_EXT |=> o_result_store) else $error("averaged in serial mode");
	ref_always_a: assert property (vref_reg == VREF_INT_ON |-> o_ref_on) // R17
		else $error("reference not held on");
endmodule // acd_decoder

`default_nettype wire

/* File: acd_host_model.sv */
// Host stand-in: drives the serial command link and the conversion start pin
`default_nettype none

module acd_host_model
(
	input  wire logic i_sys_clk,
	output logic      o_sclk,
	output logic      o_cs_b,
	output logic      o_din,
	output logic      o_conversion_start_pin_b
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Idle levels: serial clock stands still low outside frames
	// ----------------------------------------------------------------
	initial
	begin
		o_sclk    = 1'b0;
		o_cs_b    = 1'b1;
		o_din     = 1'b0;
		o_conversion_start_pin_b = 1'b1;
	end

	task automatic wait_sys(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask

	// Four system clocks per half period make the 80 ns serial clock.
	// Callers use only channels of the 16-input part and never reference code 11.
	task automatic send_byte(input logic [7:0] value);
		int i;
		o_cs_b = 1'b0;
		wait_sys(4);
		for (i = 7; i >= 0; i--)
		begin
			o_din = value[i];
			wait_sys(4);
			o_sclk = ~o_sclk;
			wait_sys(4);
			o_sclk = ~o_sclk;
		end
		wait_sys(4);
		o_cs_b = 1'b1;
		// Released data line flips so a stale bit can never pass for a good one
		o_din = ~o_din;
		wait_sys(8);
	endtask

	// Low for 40 ns; in timing mode 01 the host alone sets the sample pace
	task automatic start_pulse();
		o_conversion_start_pin_b = ~o_conversion_start_pin_b;
		wait_sys(4);
		o_conversion_start_pin_b = ~o_conversion_start_pin_b;
	endtask
endmodule // acd_host_model

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the command byte decoder and scan sequencer
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int WAKE = 16;

	typedef struct packed {
		logic [7:0] avg;
		logic [7:0] conv;
		logic [7:0] n_req;
		logic [7:0] n_store;
		logic [3:0] first;
	} acd_row_t;

	logic       clk          = 1'b0;
	logic       rst_b        = 1'b0;
	logic       sample_done  = 1'b0;
	logic       req_d        = 1'b0;
	logic       sclk;
	logic       cs_b;
	logic       din;
	logic       conversion_start_pin_b;
	logic       sample_req;
	logic       result_store;
	logic       scan_done;
	logic       busy;
	logic       ref_on;
	logic       ext_ref;
	logic       ext_conv_clk;
	logic       start_pin_en;
	logic       fifo_clear;
	logic [3:0] sample_chan;
	logic [3:0] first_ch     = 4'h0;
	int         failures     = 0;
	int         tests_run    = 0;
	int         n_req        = 0;
	int         n_store      = 0;
	int         n_done       = 0;
	int         n_clear      = 0;
	int         wake_cnt     = 0;
	acd_row_t   rows [7];

	always #5 clk = ~clk;

	acd_decoder #(.CHANNELS(16), .REF_WAKE_CYC(WAKE)) dut (
		.i_sys_clk      (clk),
		.i_rst_b        (rst_b),
		.i_sclk         (sclk),
		.i_cs_b         (cs_b),
		.i_din          (din),
		.i_conversion_start_pin_b      (conversion_start_pin_b),
		.i_sample_done  (sample_done),
		.o_sample_req   (sample_req),
		.o_sample_chan  (sample_chan),
		.o_result_store (result_store),
		.o_scan_done    (scan_done),
		.o_busy         (busy),
		.o_ref_on       (ref_on),
		.o_ext_ref      (ext_ref),
		.o_ext_conv_clk (ext_conv_clk),
		.o_start_pin_en (start_pin_en),
		.o_fifo_clear   (fifo_clear)
	);

	acd_host_model host (
		.i_sys_clk (clk),
		.o_sclk    (sclk),
		.o_cs_b    (cs_b),
		.o_din     (din),
		.o_conversion_start_pin_b (conversion_start_pin_b)
	);

	// ----------------------------------------------------------------
	// Converter stand-in and event counters
	// ----------------------------------------------------------------
	always @(negedge clk)
	begin
		req_d       <= sample_req;
		sample_done <= req_d;
	end

	// Sampled mid-cycle so the registered outputs have settled
	always @(negedge clk)
	begin
		if (busy === 1'b1 && n_req == 0 && sample_req !== 1'b1)
			wake_cnt++;
		if (sample_req === 1'b1)
		begin
			if (n_req == 0)
				first_ch = sample_chan;
			n_req++;
		end
		if (result_store === 1'b1)
			n_store++;
		if (scan_done === 1'b1)
			n_done++;
		if (fifo_clear === 1'b1)
			n_clear++;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("checks run %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic clear();
		@(negedge clk);
		n_req    = 0;
		n_store  = 0;
		n_done   = 0;
		n_clear  = 0;
		wake_cnt = 0;
	endtask

	task automatic wait_done();
		int k;
		for (k = 0; k < 4000 && n_done == 0; k++)
			@(negedge clk);
		if (n_done == 0)
		begin
			failures++;
			$display("ERROR o_scan_done expected 1 seen 0");
			summarize();
		end
		repeat (2) @(negedge clk);
	endtask

	// Setup byte, averaging byte, then a serial conversion write; checks the scan
	task automatic run(input logic [7:0] setup, input acd_row_t r);
		host.send_byte(setup);
		host.send_byte(r.avg);
		clear();
		host.send_byte(r.conv);
		wait_done();
		check("sample count", {24'h0, r.n_req}, n_req);
		check("result count", {24'h0, r.n_store}, n_store);
		check("first channel", {28'h0, r.first}, {28'h0, first_ch});
		check("wake delay", {31'h0, setup[3:2] == 2'b00}, wake_cnt >= WAKE);
		check("o_ext_ref", {31'h0, setup[3:2] == 2'b01}, {31'h0, ext_ref});
		check("o_ref_on idle", {31'h0, setup[3:2] == 2'b10}, {31'h0, ref_on});
		check("o_busy after scan", 32'h0, {31'h0, busy});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rows = '{
			'{8'h20, 8'h98, 8'd4, 8'd4, 4'h0},
			'{8'h20, 8'hEA, 8'd3, 8'd3, 4'hD},
			'{8'h23, 8'hAC, 8'd16, 8'd16, 4'h5},
			'{8'h20, 8'hFE, 8'd1, 8'd1, 4'hF},
			'{8'h3C, 8'h96, 8'd32, 8'd1, 4'h2},
			'{8'h31, 8'h8C, 8'd32, 8'd8, 4'h1},
			'{8'h38, 8'h88, 8'd32, 8'd2, 4'h0}
		};
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		check("o_start_pin_en", 32'h0, {31'h0, start_pin_en});
		check("o_ext_conv_clk", 32'h0, {31'h0, ext_conv_clk});
		check("o_ref_on", 32'h0, {31'h0, ref_on});
		// Zero bytes select no register, so defaults stay in force
		run(8'h00, '{8'h00, 8'hFE, 8'd1, 8'd1, 4'hF});
		foreach (rows[i])
			run(8'h64, rows[i]);
		run(8'h68, rows[0]);
		run(8'h74, '{8'h3C, 8'h98, 8'd1, 8'd1, 4'h3});
		check("o_ext_conv_clk", 32'h1, {31'h0, ext_conv_clk});
		// Pin-started mode: serial write must not start, last channel is the pin
		host.send_byte(8'h44);
		host.send_byte(8'h3C);
		clear();
		host.send_byte(8'hEA);
		repeat (40) @(negedge clk);
		check("serial start in pin mode", 32'h0, n_req);
		check("o_start_pin_en", 32'h1, {31'h0, start_pin_en});
		host.start_pulse();
		wait_done();
		check("pin scan samples", 32'd64, n_req);
		check("pin scan results", 32'd2, n_store);
		clear();
		host.send_byte(8'h18);
		check("fifo clear pulses", 32'h1, n_clear);
		check("setup kept", 32'h1, {31'h0, start_pin_en});
		host.send_byte(8'h10);
		check("o_start_pin_en", 32'h0, {31'h0, start_pin_en});
		check("o_ext_ref", 32'h0, {31'h0, ext_ref});
		run(8'h00, '{8'h00, 8'h98, 8'd4, 8'd4, 4'h0});
		summarize();
	end
endmodule // tb

`default_nettype wire
